/* File: bench/sfpd_periph_model.sv */
// Peripheral register files seen from the decoder's peripheral port
// Assumes strobes are one-cycle pulses and read data is wanted in the same cycle
`timescale 1ns/1ns
module sfpd_periph_model
    import sfpd_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Strobe and target
    input wire logic periph_sel,
    input wire logic periph_rd,
    input wire logic [7:0] periph_addr,
    input wire logic [7:0] periph_page,
    // Answer
    output logic [7:0] periph_rdata
);
    logic [7:0] idle_r = 8'h00;
    // Changing filler so a stale answer is never mistaken for a fresh one
    always @(posedge ref_clk) begin
        idle_r <= idle_r + 8'h01;
    end
    // Each answer is the address XOR the page XOR 0x5A, so the page changes the value
    assign periph_rdata = (periph_sel && periph_rd) ? (periph_addr ^ periph_page ^ 8'h5A) : ~idle_r;
endmodule // sfpd_periph_model

/* File: bench/tb.sv */
// Self-checking bench of the register-space page decoder
// Assumes the peripheral model answers reads combinationally
`timescale 1ns/1ns
module tb;
    import sfpd_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] pg; logic bt; logic dr; logic sl; logic rf; logic [7:0] pp;} sfpd_row_t;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic core_direct = 1'b0, core_rd = 1'b0, core_wr = 1'b0, core_bit = 1'b0;
    logic [7:0] core_addr = 8'h00, core_wdata = 8'h00;
    logic [7:0] core_rdata, register_page_select, periph_addr, periph_page, periph_wdata, periph_rdata;
    logic core_rvalid, core_bit_refused, periph_sel, periph_rd, periph_wr, periph_bit;
    int num_errors = 0;
    int n_tests = 0;
    logic exp_rv;
    // Address, page, bit, direct, strobe, refused, page sent out
    sfpd_row_t rows[16] = '{'{8'h80, 8'h00, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00},
        '{8'h80, 8'h0F, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00}, '{8'hBA, 8'h00, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00},
        '{8'hBA, 8'h0F, 1'b0, 1'b1, 1'b1, 1'b0, 8'h0F}, '{8'hBA, 8'h0F, 1'b1, 1'b1, 1'b0, 1'b1, 8'h00},
        '{8'hAB, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00}, '{8'h85, 8'h0F, 1'b0, 1'b1, 1'b1, 1'b0, 8'h0F},
        '{8'hB4, 8'h0F, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00}, '{8'h88, 8'h00, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00},
        '{8'h90, 8'h03, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00}, '{8'hC0, 8'h03, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00},
        '{8'h90, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00}, '{8'h7F, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00},
        '{8'hE0, 8'h0F, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00}, '{8'hB4, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00},
        '{8'hBA, 8'h05, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00}};
    sfpd_decoder i_sfpd_decoder (.ref_clk(ref_clk), .reset_n(reset_n), .core_direct(core_direct),
        .core_addr(core_addr), .core_rd(core_rd), .core_wr(core_wr), .core_bit(core_bit), .core_wdata(core_wdata),
        .core_rdata(core_rdata), .core_rvalid(core_rvalid), .core_bit_refused(core_bit_refused),
        .register_page_select(register_page_select), .periph_sel(periph_sel), .periph_rd(periph_rd),
        .periph_wr(periph_wr), .periph_bit(periph_bit), .periph_addr(periph_addr), .periph_page(periph_page),
        .periph_wdata(periph_wdata), .periph_rdata(periph_rdata));
    sfpd_periph_model i_sfpd_periph_model (.ref_clk(ref_clk), .periph_sel(periph_sel), .periph_rd(periph_rd),
        .periph_addr(periph_addr), .periph_page(periph_page), .periph_rdata(periph_rdata));
    // Free-running clock
    always #5 ref_clk = ~ref_clk;
    // Byte results
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Single-bit results; kept apart so no flag is padded or cut
    task automatic chk_flag(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    // One request, op is {rd, wr, bit, direct}; returns in the cycle after the taking edge
    task automatic acc(input logic [3:0] op, input logic [7:0] a, input logic [7:0] wd);
        @(posedge ref_clk);
        #1;
        {core_rd, core_wr, core_bit, core_direct, core_addr, core_wdata} = {op, a, wd};
        @(posedge ref_clk);
        #1;
        {core_rd, core_wr} = 2'b00;
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Watchdog well beyond the roughly 114 cycles the tests need
    initial begin
        #20000;
        num_errors++;
        conclude();
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        chk(register_page_select, SFPD_PAGE_SEL_RST);
        chk_flag(periph_sel, 1'b0);
        chk_flag(core_rvalid, 1'b0);
        foreach (rows[i]) begin
            acc(4'b0101, SFPD_PAGE_SEL_ADDR, rows[i].pg);
            acc({2'b10, rows[i].bt, rows[i].dr}, rows[i].a, 8'h00);
            chk_flag(periph_sel, rows[i].sl);
            chk_flag(core_bit_refused, rows[i].rf);
            if (rows[i].sl) begin
                chk(periph_page, rows[i].pp);
                chk(periph_addr, rows[i].a);
                chk_flag(periph_bit, rows[i].bt);
            end
            @(posedge ref_clk);
            #1;
            exp_rv = rows[i].dr && rows[i].a >= SFPD_SPACE_LO && !rows[i].rf;
            chk_flag(core_rvalid, exp_rv);
            if (exp_rv) begin
                chk(core_rdata, rows[i].sl ? rows[i].a ^ rows[i].pp ^ 8'h5A : SFPD_EMPTY_DATA);
            end
        end
        $display("test table done");
        // Page write then read in the very next cycle
        @(posedge ref_clk);
        #1;
        {core_wr, core_bit, core_direct, core_addr, core_wdata} = {1'b1, 1'b0, 1'b1, SFPD_PAGE_SEL_ADDR, SFPD_PAGE_F};
        @(posedge ref_clk);
        #1;
        {core_rd, core_wr, core_addr} = {1'b1, 1'b0, SFPD_ADC_SPLIT_ADDR};
        @(posedge ref_clk);
        #1;
        core_rd = 1'b0;
        chk_flag(periph_sel, 1'b1);
        chk(periph_page, SFPD_PAGE_F);
        // Read-modify-write and a bit write refused at the selector
        acc(4'b1101, SFPD_ADC_SPLIT_ADDR, 8'h3C);
        chk_flag(periph_rd, 1'b1);
        chk_flag(periph_wr, 1'b1);
        chk(periph_wdata, 8'h3C);
        acc(4'b0111, SFPD_PAGE_SEL_ADDR, 8'h00);
        chk_flag(core_bit_refused, 1'b1);
        chk(register_page_select, SFPD_PAGE_F);
        acc(4'b1001, SFPD_PAGE_SEL_ADDR, 8'h00);
        @(posedge ref_clk);
        #1;
        chk_flag(core_rvalid, 1'b1);
        chk(core_rdata, SFPD_PAGE_F);
        // Reserved slot written on purpose: it must never reach a peripheral
        acc(4'b0101, 8'hAB, 8'h55);
        chk_flag(periph_sel, 1'b0);
        // Unpopulated page keeps a paged address away from the peripherals
        acc(4'b0101, SFPD_PAGE_SEL_ADDR, 8'h05);
        acc(4'b0101, SFPD_ADC_SPLIT_ADDR, 8'h77);
        chk_flag(periph_sel, 1'b0);
        // Page 0xF visit in the guarded order; the interrupt enable lives outside this block
        acc(4'b0101, SFPD_PAGE_SEL_ADDR, SFPD_PAGE_F);
        acc(4'b1001, SFPD_ADC_SPLIT_ADDR, 8'h00);
        chk_flag(periph_sel, 1'b1);
        chk(periph_page, SFPD_PAGE_F);
        acc(4'b0101, SFPD_PAGE_SEL_ADDR, SFPD_PAGE_0);
        acc(4'b1001, SFPD_ADC_SPLIT_ADDR, 8'h00);
        chk(periph_page, SFPD_PAGE_0);
        $display("test order done");
        // Second reset in mid-run returns to page 0x0
        acc(4'b0101, SFPD_PAGE_SEL_ADDR, SFPD_PAGE_F);
        reset_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        chk(register_page_select, SFPD_PAGE_0);
        chk_flag(periph_sel, 1'b0);
        chk_flag(core_rvalid, 1'b0);
        acc(4'b1001, SFPD_ADC_SPLIT_ADDR, 8'h00);
        chk_flag(periph_sel, 1'b1);
        chk(periph_page, SFPD_PAGE_0);
        $display("test reset done");
        conclude();
    end
endmodule // tb

/* File: hw/sfpd_decoder.sv */
// Register-space page decoder between the core and the peripheral registers
// Assumes peripherals answer reads combinationally in the cycle of their strobe
`timescale 1ns/1ns
module sfpd_decoder
    import sfpd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Core access request
    input wire logic core_direct,
    input wire logic [7:0] core_addr,
    input wire logic core_rd,
    input wire logic core_wr,
    input wire logic core_bit,
    input wire logic [7:0] core_wdata,
    // Core answer
    output logic [7:0] core_rdata,
    output logic core_rvalid,
    output logic core_bit_refused,
    output logic [7:0] register_page_select,
    // Peripheral register port
    output logic periph_sel,
    output logic periph_rd,
    output logic periph_wr,
    output logic periph_bit,
    output logic [7:0] periph_addr,
    output logic [7:0] periph_page,
    output logic [7:0] periph_wdata,
    input wire logic [7:0] periph_rdata
);
    typedef struct packed {
        logic [7:0] page;
        logic sel;
        logic rd;
        logic wr;
        logic bitacc;
        logic [7:0] addr;
        logic [7:0] ppage;
        logic [7:0] wdata;
        logic rd_periph;
        logic rd_local;
        logic rd_empty;
        logic rvalid;
        logic [7:0] rdata;
        logic refused;
    } sfpd_state_t;

    sfpd_state_t st_r;
    sfpd_state_t st_nxt;
    sfpd_cls_t cls;
    logic in_space;
    logic bit_ok;
    logic is_page_reg;
    logic occupied;

    // Occupancy lookup under the current page
    sfpd_map u_map (
        .addr(core_addr),
        .page(st_r.page),
        .cls(cls)
    );

    // Whole upper half is register space for direct addressing
    assign in_space = core_direct && core_addr >= SFPD_SPACE_LO && core_addr <= SFPD_SPACE_HI;
    assign bit_ok = core_addr[3:0] == SFPD_BIT_NIB_A || core_addr[3:0] == SFPD_BIT_NIB_B;
    assign is_page_reg = core_addr == SFPD_PAGE_SEL_ADDR;
    assign occupied = cls != SFPD_CLS_NONE;

    // Next-state; reads answer two cycles after the request
    always_comb begin
        st_nxt = st_r;
        st_nxt.sel = 1'b0;
        st_nxt.rd = 1'b0;
        st_nxt.wr = 1'b0;
        st_nxt.rd_periph = 1'b0;
        st_nxt.rd_local = 1'b0;
        st_nxt.rd_empty = 1'b0;
        st_nxt.refused = 1'b0;
        // Second stage: collect the read answer
        st_nxt.rvalid = st_r.rd_periph || st_r.rd_local || st_r.rd_empty;
        if (st_r.rd_periph) begin
            st_nxt.rdata = periph_rdata;
        end else if (st_r.rd_local) begin
            st_nxt.rdata = st_r.page;
        end else if (st_r.rd_empty) begin
            st_nxt.rdata = SFPD_EMPTY_DATA;
        end
        // First stage: decode the request
        if (in_space && (core_rd || core_wr)) begin
            if (core_bit && !bit_ok) begin
                // Refused bit access leaves every register untouched
                st_nxt.refused = 1'b1;
            end else if (is_page_reg) begin
                // Selector is local; a read-modify-write reads back the newly written page
                st_nxt.rd_local = core_rd;
                if (core_wr) begin
                    st_nxt.page = core_wdata[SFPD_PAGE_SEL_MSB:SFPD_PAGE_SEL_LSB];
                end
            end else if (occupied) begin
                st_nxt.sel = 1'b1;
                st_nxt.rd = core_rd;
                st_nxt.wr = core_wr;
                st_nxt.bitacc = core_bit;
                st_nxt.addr = core_addr;
                st_nxt.wdata = core_wdata;
                st_nxt.rd_periph = core_rd;
                // Shared entries always carry page 0x0 so one copy serves both
                st_nxt.ppage = (cls == SFPD_CLS_SHARED) ? SFPD_PAGE_0 : st_r.page;
            end else begin
                st_nxt.rd_empty = core_rd;
            end
        end
    end

    // State register; synchronous reset puts the selector on page 0x0
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            st_r <= '0;
            st_r.page <= SFPD_PAGE_SEL_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign core_rdata = st_r.rdata;
    assign core_rvalid = st_r.rvalid;
    assign core_bit_refused = st_r.refused;
    assign register_page_select = st_r.page;
    assign periph_sel = st_r.sel;
    assign periph_rd = st_r.rd;
    assign periph_wr = st_r.wr;
    assign periph_bit = st_r.bitacc;
    assign periph_addr = st_r.addr;
    assign periph_page = st_r.ppage;
    assign periph_wdata = st_r.wdata;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Nothing below the register space reaches the peripherals
    space_low_ignored_a: assert property (
        !core_direct || !core_addr[7]
        |=> !periph_sel)
        else $error("Access below 0x80 reached the register port");
    // Every accepted read is answered two cycles later
    read_answer_a: assert property (
        in_space && core_rd && (!core_bit || bit_ok)
        |=> ##1 core_rvalid)
        else $error("Register read got no answer");

    // Bit strobes only at nibble 0x0 or 0x8
    bit_nibble_a: assert property (
        periph_sel && periph_bit
        |-> periph_addr[2:0] == 3'h0)
        else $error("Bit access passed at a byte-only address");
    bit_refuse_a: assert property (
        in_space && core_bit && core_rd && !bit_ok
        |=> core_bit_refused && !periph_sel)
        else $error("Bit access at byte-only address not refused");
    // A refused access must not fake an answer later
    refuse_quiet_a: assert property (
        in_space && core_bit && (core_rd || core_wr) && !bit_ok
        |=> ##1 !core_rvalid)
        else $error("Refused bit access produced read data");

    // Reset state and routing to page 0x0
    reset_page_a: assert property (
        $rose(reset_n)
        |-> register_page_select == 8'h00)
        else $error("Page selector not zero after reset");
    // Checked during reset itself, so the default disable is lifted
    reset_idle_a: assert property (
        disable iff (1'b0)
        !reset_n
        |=> !periph_sel && !core_rvalid && !core_bit_refused && register_page_select == SFPD_PAGE_SEL_RST)
        else $error("Outputs not idle during reset");
    page0_route_a: assert property (
        in_space && core_rd && core_addr == 8'h88 && register_page_select == SFPD_PAGE_0
        |=> periph_sel && periph_page == SFPD_PAGE_0)
        else $error("Default page access not routed to page 0x0");

    // Shared registers carry page 0x0 whatever the selector
    shared_page_a: assert property (
        in_space && core_rd && core_addr == 8'hE0
        |=> periph_sel && periph_page == 8'h00)
        else $error("Shared register carried a nonzero page");
    shared_port_a: assert property (
        in_space && core_rd && core_addr == 8'h80
        |=> periph_sel && periph_addr == 8'h80 && periph_page == SFPD_PAGE_0)
        else $error("Shared port register not decoded alike");

    // Selector is local and lands at once
    page_write_a: assert property (
        in_space && core_wr && !core_bit && core_addr == 8'hA7
        |=> register_page_select == $past(core_wdata))
        else $error("Page selector write lost");
    page_local_a: assert property (
        in_space && (core_rd || core_wr) && is_page_reg
        |=> !periph_sel)
        else $error("Page selector access leaked to the peripherals");
    page_read_a: assert property (
        in_space && core_rd && !core_wr && !core_bit && core_addr == 8'hA7
        |=> ##1 core_rvalid && core_rdata == $past(register_page_select, 2))
        else $error("Page selector read wrong");
    // Only a write to the selector may move it
    page_hold_a: assert property (
        !(in_space && core_wr && is_page_reg)
        |=> $stable(register_page_select))
        else $error("Page selector changed without a write");
    rmw_pass_a: assert property (
        in_space && core_rd && core_wr && !core_bit && core_addr == 8'hBA && register_page_select == SFPD_PAGE_F
        |=> periph_sel && periph_rd && periph_wr && periph_wdata == $past(core_wdata))
        else $error("Read-modify-write not passed whole");

    // Paged targets: page 0xF window and unpopulated pages
    page_f_route_a: assert property (
        in_space && core_rd && !core_bit && core_addr == 8'h85 && register_page_select == SFPD_PAGE_F
        |=> periph_sel && periph_page == SFPD_PAGE_F)
        else $error("Page 0xF register not reached");
    page_f_hole_a: assert property (
        in_space && core_rd && !core_bit && core_addr == 8'hB4 && register_page_select == SFPD_PAGE_F
        |=> !periph_sel ##1 core_rvalid && core_rdata == SFPD_EMPTY_DATA)
        else $error("Empty page 0xF slot reached a register");
    other_page_empty_a: assert property (
        in_space && core_wr && core_addr == 8'hBA && register_page_select == 8'h05
        |=> !periph_sel)
        else $error("Unpopulated page reached a register");

    // One address, two targets picked by the page
    adc_split_a: assert property (
        in_space && core_rd && core_addr == 8'hBA && !core_bit
        && (register_page_select == 8'h0F || register_page_select == 8'h00)
        |=> periph_sel && periph_page == $past(register_page_select))
        else $error("Address 0xBA not routed by page");
    // Byte reads of a hole answer zero without a strobe
    empty_zero_a: assert property (
        in_space && core_rd && !core_wr && !core_bit && core_addr == 8'hB4 && register_page_select == 8'h00
        |=> !periph_sel ##1 core_rvalid && core_rdata == 8'h00)
        else $error("Unoccupied read not zero");
endmodule // sfpd_decoder

/* File: hw/sfpd_map.sv */
// Occupancy map of the register space for page 0x0 and page 0xF
// Assumes the caller has already checked that the address is in the space
`timescale 1ns/1ns
module sfpd_map
    import sfpd_pkg::*;
(
    // Lookup
    input wire logic [7:0] addr,
    input wire logic [7:0] page,
    // Result
    output sfpd_cls_t cls
);
    // Registers decoded the same on both pages
    function automatic logic is_shared(input logic [7:0] a);
        unique case (a)
            8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h90, 8'hA0, 8'hA7,
            8'hA8, 8'hA9, 8'hD0, 8'hE0, 8'hE6, 8'hE7, 8'hF0, 8'hF6,
            8'hF7: is_shared = 1'b1;
            default: is_shared = 1'b0;
        endcase
    endfunction

    // Registers seen only while page 0xF is selected
    function automatic logic is_page_f(input logic [7:0] a);
        unique case (a)
            8'h85, 8'h86, 8'h91, 8'h92, 8'h93, 8'h95, 8'h96, 8'h97,
            8'hA4, 8'hA5, 8'hA6, 8'hBA, 8'hBD: is_page_f = 1'b1;
            default: is_page_f = 1'b0;
        endcase
    endfunction

    // Holes in page 0x0, including the reserved slots
    function automatic logic is_page0_hole(input logic [7:0] a);
        unique case (a)
            8'hAB, 8'hAF, 8'hB4, 8'hB9, 8'hE5: is_page0_hole = 1'b1;
            default: is_page0_hole = 1'b0;
        endcase
    endfunction

    // Shared entries ignore the page; other pages hold nothing
    always_comb begin
        if (is_shared(addr)) begin
            cls = SFPD_CLS_SHARED;
        end else if (page == SFPD_PAGE_0 && !is_page0_hole(addr)) begin
            cls = SFPD_CLS_PAGED;
        end else if (page == SFPD_PAGE_F && is_page_f(addr)) begin
            cls = SFPD_CLS_PAGED;
        end else begin
            cls = SFPD_CLS_NONE;
        end
    end
endmodule // sfpd_map

/* File: hw/sfpd_pkg.sv */
// Constants shared by the register-space page decoder and its map
// Assumes an 8-bit core address and an 8-bit data path
package sfpd_pkg;
    // Address range of the register space
    localparam logic [7:0] SFPD_SPACE_LO = 8'h80;
    localparam logic [7:0] SFPD_SPACE_HI = 8'hFF;
    // Bit access allowed on these low nibbles
    localparam logic [3:0] SFPD_BIT_NIB_A = 4'h0;
    localparam logic [3:0] SFPD_BIT_NIB_B = 4'h8;
    // Page selector register
    localparam logic [7:0] SFPD_PAGE_SEL_ADDR = 8'hA7;
    localparam logic [7:0] SFPD_PAGE_SEL_RST = 8'h00;
    localparam int SFPD_PAGE_SEL_MSB = 7;
    localparam int SFPD_PAGE_SEL_LSB = 0;
    // Page numbers
    localparam logic [7:0] SFPD_PAGE_0 = 8'h00;
    localparam logic [7:0] SFPD_PAGE_F = 8'h0F;
    // Address whose target depends on the page
    localparam logic [7:0] SFPD_ADC_SPLIT_ADDR = 8'hBA;
    // Answer for unoccupied addresses
    localparam logic [7:0] SFPD_EMPTY_DATA = 8'h00;

    // Occupancy classes
    typedef enum logic [2:0] {
        SFPD_CLS_NONE   = 3'b001,
        SFPD_CLS_SHARED = 3'b010,
        SFPD_CLS_PAGED  = 3'b100
    } sfpd_cls_t;
endpackage
